/* File: verilog/mbsra_pkg.sv */
// Package with constants shared by the register access handler
package mbsra_pkg;
   // AXI4-Lite register byte offsets
   localparam logic [7:0] REQ_CMD_OFF = 8'h00;
   localparam logic [7:0] REQ_ADDR_OFF = 8'h04;
   localparam logic [7:0] REQ_DATA_OFF = 8'h08;
   localparam logic [7:0] RSP_OFF = 8'h0C;
   localparam logic [7:0] CFG_ID_OFF = 8'h10;
   localparam logic [7:0] CFG_IP_OFF = 8'h14;
   localparam logic [7:0] CFG_MASK_OFF = 8'h18;
   localparam logic [7:0] CFG_GW_OFF = 8'h1C;
   localparam logic [7:0] CFG_CTRL_OFF = 8'h20;
   localparam logic [7:0] ACT_ID_OFF = 8'h24;
   localparam logic [7:0] ACT_IP_OFF = 8'h28;
   localparam logic [7:0] ACT_MASK_OFF = 8'h2C;
   localparam logic [7:0] ACT_GW_OFF = 8'h30;
   localparam logic [7:0] ACT_CTRL_OFF = 8'h34;
   localparam logic [7:0] RO_WR_OFF = 8'h38;
   // Function codes
   localparam logic [7:0] FC_RD_BIT_OUT = 8'h01;
   localparam logic [7:0] FC_RD_BIT_IN = 8'h02;
   localparam logic [7:0] FC_RD_RW = 8'h03;
   localparam logic [7:0] FC_RD_RO = 8'h04;
   localparam logic [7:0] FC_WR_ONE = 8'h06;
   localparam logic [7:0] FC_WR_MULTI = 8'h10;
   // Exception codes
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   // Register space: wire addresses 0..WORD_TOP are generated
   localparam int WORD_AW = 10;
   localparam int WORD_DEPTH = 1000;
   localparam logic [15:0] WORD_TOP = 16'h03E7;
   // Slave identifier range and defaults
   localparam logic [7:0] ID_MIN = 8'h01;
   localparam logic [7:0] ID_MAX = 8'hF7;
   localparam logic [7:0] ID_RST = 8'h01;
   localparam logic [31:0] IP_RST = 32'hC0A8012A;
   localparam logic [31:0] MASK_RST = 32'hFFFFFF00;
   localparam logic [31:0] GW_RST = 32'hC0A80101;
   localparam logic [15:0] TCP_PORT = 16'h01F6;
   // Control bits
   localparam int CTRL_DHCP = 0;
   localparam int CTRL_RESTART = 1;
   localparam int CMD_GO = 31;
   localparam int CMD_SERIAL = 30;
   localparam int CMD_CRC_OK = 29;
   localparam int RSP_DONE = 31;
   localparam int RSP_DROP = 30;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/mbsra_word_if.sv */
// Interface between request engine and word store
`timescale 1ns/10ps
`default_nettype none
interface mbsra_word_if;
   logic rd_ro;
   logic [9:0] addr;
   logic we;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport engine (output rd_ro, output addr, output we, output wdata, input rdata);
   modport store (input rd_ro, input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: verilog/mbsra_word_store.sv */
// Word store holding read-only and read/write register spaces
`timescale 1ns/10ps
`default_nettype none
module mbsra_word_store (
   // Clock
   input wire logic aclk,
   // Engine side
   mbsra_word_if.store wp,
   // Software load of read-only words
   input wire logic ro_we,
   input wire logic [9:0] ro_addr,
   input wire logic [15:0] ro_wdata
);
   logic [15:0] ro_mem [mbsra_pkg::WORD_DEPTH];
   logic [15:0] rw_mem [mbsra_pkg::WORD_DEPTH];
   logic [15:0] rdata_ff;
   assign wp.rdata = rdata_ff;
   always_ff @(posedge aclk) begin
      if (ro_we) begin
         ro_mem[ro_addr] <= ro_wdata;
      end
      if (wp.we) begin
         rw_mem[wp.addr] <= wp.wdata;
      end
      rdata_ff <= wp.rd_ro ? ro_mem[wp.addr] : rw_mem[wp.addr];
   end
endmodule
`default_nettype wire

/* File: verilog/mbsra_top.sv */
// Request handler top: AXI4-Lite command port, request engine, settings
`timescale 1ns/10ps
`default_nettype none
module mbsra_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Settings in force
   output logic [15:0] tcp_port
);
   typedef enum {ST_IDLE, ST_RD, ST_WR, ST_DONE} mbsra_state_t;
   mbsra_word_if wif ();
   mbsra_state_t state_ff, nxt_state;
   logic [7:0] fc_ff, exc_ff;
   logic [15:0] start_ff, qty_ff, data_ff, cnt_ff, word_ff;
   logic done_ff, drop_ff, busy_ff;
   logic [31:0] rdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic bvalid_ff, rvalid_ff;
   logic [7:0] cfg_id_ff, act_id_ff;
   logic [31:0] cfg_ip_ff, cfg_mask_ff, cfg_gw_ff, act_ip_ff, act_mask_ff, act_gw_ff;
   logic cfg_dhcp_ff, act_dhcp_ff;
   logic [9:0] ro_addr_ff;
   logic [15:0] ro_data_ff;
   logic ro_we_ff;

   // Write channel: both address and data must be present
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   wire rd_go = s_axi_arvalid && !rvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign tcp_port = mbsra_pkg::TCP_PORT;

   wire full_word = s_axi_wstrb == 4'hF;
   wire sel_cmd = s_axi_awaddr == mbsra_pkg::REQ_CMD_OFF;
   wire sel_addr = s_axi_awaddr == mbsra_pkg::REQ_ADDR_OFF;
   wire sel_data = s_axi_awaddr == mbsra_pkg::REQ_DATA_OFF;
   wire sel_cid = s_axi_awaddr == mbsra_pkg::CFG_ID_OFF;
   wire sel_cip = s_axi_awaddr == mbsra_pkg::CFG_IP_OFF;
   wire sel_cmask = s_axi_awaddr == mbsra_pkg::CFG_MASK_OFF;
   wire sel_cgw = s_axi_awaddr == mbsra_pkg::CFG_GW_OFF;
   wire sel_cctl = s_axi_awaddr == mbsra_pkg::CFG_CTRL_OFF;
   wire sel_ro = s_axi_awaddr == mbsra_pkg::RO_WR_OFF;
   wire wr_hit = sel_cmd || sel_addr || sel_data || sel_cid || sel_cip || sel_cmask
      || sel_cgw || sel_cctl || sel_ro;
   wire wr_ok = wr_go && wr_hit && full_word;
   wire ro_in_range = s_axi_wdata[31:16] <= mbsra_pkg::WORD_TOP;

   // Request decode
   wire cmd_go = wr_ok && sel_cmd && s_axi_wdata[mbsra_pkg::CMD_GO] && !busy_ff;
   wire [7:0] cmd_fc = s_axi_wdata[7:0];
   wire [7:0] cmd_id = s_axi_wdata[15:8];
   wire cmd_ser = s_axi_wdata[mbsra_pkg::CMD_SERIAL];
   wire cmd_crc = s_axi_wdata[mbsra_pkg::CMD_CRC_OK];
   wire id_valid = act_id_ff >= mbsra_pkg::ID_MIN && act_id_ff <= mbsra_pkg::ID_MAX;
   wire foreign = cmd_ser && (cmd_id != act_id_ff || !id_valid);
   wire drop_now = foreign || (cmd_ser && !cmd_crc);
   wire fc_read = cmd_fc == mbsra_pkg::FC_RD_RW || cmd_fc == mbsra_pkg::FC_RD_RO;
   wire fc_wr = cmd_fc == mbsra_pkg::FC_WR_ONE || cmd_fc == mbsra_pkg::FC_WR_MULTI;
   wire fc_ok = fc_read || fc_wr;
   wire [15:0] eff_qty = cmd_fc == mbsra_pkg::FC_WR_ONE ? 16'h0001 : qty_ff;
   wire [16:0] last_addr = {1'b0, start_ff} + {1'b0, eff_qty} - 17'h00001;
   wire [16:0] cur_addr = {1'b0, start_ff} + {1'b0, cnt_ff};
   wire range_bad = eff_qty == 16'h0000 || last_addr > {1'b0, mbsra_pkg::WORD_TOP}
      || cur_addr > {1'b0, mbsra_pkg::WORD_TOP};
   wire [7:0] nxt_exc = !fc_ok ? mbsra_pkg::EXC_FUNC
      : (range_bad ? mbsra_pkg::EXC_ADDR : mbsra_pkg::EXC_NONE);
   // A new start address restarts the word step of multi-word transfers
   wire ld_start = wr_ok && sel_addr && !busy_ff;
   wire done_wr = fc_ff == mbsra_pkg::FC_WR_ONE || fc_ff == mbsra_pkg::FC_WR_MULTI;

   // Word store port: space chosen only by the function code
   assign wif.rd_ro = fc_ff == mbsra_pkg::FC_RD_RO;
   assign wif.addr = cur_addr[9:0];
   assign wif.we = state_ff == ST_WR;
   assign wif.wdata = data_ff;

   mbsra_word_store u_store (
      .aclk(aclk),
      .wp(wif.store),
      .ro_we(ro_we_ff),
      .ro_addr(ro_addr_ff),
      .ro_wdata(ro_data_ff)
   );

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (cmd_go && !drop_now && nxt_exc == mbsra_pkg::EXC_NONE) begin
               nxt_state = fc_read ? ST_RD : ST_WR;
            end
         end
         ST_RD: nxt_state = ST_DONE;
         ST_WR: nxt_state = ST_DONE;
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Engine: one word per request step; multi-word transfers step cnt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         fc_ff <= 8'h00;
         exc_ff <= mbsra_pkg::EXC_NONE;
         cnt_ff <= 16'h0000;
         word_ff <= 16'h0000;
         done_ff <= 1'b0;
         drop_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (cmd_go) begin
            fc_ff <= cmd_fc;
            drop_ff <= drop_now;
            exc_ff <= drop_now ? mbsra_pkg::EXC_NONE : nxt_exc;
            done_ff <= drop_now || nxt_exc != mbsra_pkg::EXC_NONE;
            busy_ff <= !drop_now && nxt_exc == mbsra_pkg::EXC_NONE;
         end else if (state_ff == ST_DONE) begin
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
            if (fc_ff != mbsra_pkg::FC_WR_ONE) begin
               cnt_ff <= cnt_ff + 16'h0001;
            end
         end else if (ld_start) begin
            cnt_ff <= 16'h0000;
         end
         // Writes report the word stored, reads the word fetched
         if (state_ff == ST_DONE) begin
            word_ff <= done_wr ? data_ff : wif.rdata;
         end
      end
   end

   // Request operand registers and word load port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_ff <= 16'h0000;
         qty_ff <= 16'h0001;
         data_ff <= 16'h0000;
         ro_we_ff <= 1'b0;
         ro_addr_ff <= 10'h000;
         ro_data_ff <= 16'h0000;
      end else begin
         ro_we_ff <= wr_ok && sel_ro && ro_in_range;
         if (wr_ok && sel_ro) begin
            ro_addr_ff <= s_axi_wdata[25:16];
            ro_data_ff <= s_axi_wdata[15:0];
         end
         if (wr_ok && sel_addr && !busy_ff) begin
            start_ff <= s_axi_wdata[15:0];
            qty_ff <= s_axi_wdata[31:16];
         end
         if (wr_ok && sel_data && !busy_ff) begin
            data_ff <= s_axi_wdata[15:0];
         end
      end
   end

   // Staged settings and settings in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_id_ff <= mbsra_pkg::ID_RST;
         cfg_ip_ff <= mbsra_pkg::IP_RST;
         cfg_mask_ff <= mbsra_pkg::MASK_RST;
         cfg_gw_ff <= mbsra_pkg::GW_RST;
         cfg_dhcp_ff <= 1'b0;
         act_id_ff <= mbsra_pkg::ID_RST;
         act_ip_ff <= mbsra_pkg::IP_RST;
         act_mask_ff <= mbsra_pkg::MASK_RST;
         act_gw_ff <= mbsra_pkg::GW_RST;
         act_dhcp_ff <= 1'b0;
      end else begin
         if (wr_ok && sel_cid) cfg_id_ff <= s_axi_wdata[7:0];
         if (wr_ok && sel_cip) cfg_ip_ff <= s_axi_wdata;
         if (wr_ok && sel_cmask) cfg_mask_ff <= s_axi_wdata;
         if (wr_ok && sel_cgw) cfg_gw_ff <= s_axi_wdata;
         if (wr_ok && sel_cctl) cfg_dhcp_ff <= s_axi_wdata[mbsra_pkg::CTRL_DHCP];
         if (wr_ok && sel_cctl && s_axi_wdata[mbsra_pkg::CTRL_RESTART]) begin
            act_id_ff <= cfg_id_ff;
            act_ip_ff <= cfg_ip_ff;
            act_mask_ff <= cfg_mask_ff;
            act_gw_ff <= cfg_gw_ff;
            act_dhcp_ff <= cfg_dhcp_ff;
         end
      end
   end

   // Read decode
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         mbsra_pkg::REQ_CMD_OFF: rd_mux = {24'h000000, fc_ff};
         mbsra_pkg::REQ_ADDR_OFF: rd_mux = {qty_ff, start_ff};
         mbsra_pkg::REQ_DATA_OFF: rd_mux = {16'h0000, data_ff};
         mbsra_pkg::RSP_OFF: rd_mux = {done_ff, drop_ff, 6'h00, exc_ff, word_ff};
         mbsra_pkg::CFG_ID_OFF: rd_mux = {24'h000000, cfg_id_ff};
         mbsra_pkg::CFG_IP_OFF: rd_mux = cfg_ip_ff;
         mbsra_pkg::CFG_MASK_OFF: rd_mux = cfg_mask_ff;
         mbsra_pkg::CFG_GW_OFF: rd_mux = cfg_gw_ff;
         mbsra_pkg::CFG_CTRL_OFF: rd_mux = {31'h00000000, cfg_dhcp_ff};
         mbsra_pkg::ACT_ID_OFF: rd_mux = {24'h000000, act_id_ff};
         mbsra_pkg::ACT_IP_OFF: rd_mux = act_ip_ff;
         mbsra_pkg::ACT_MASK_OFF: rd_mux = act_mask_ff;
         mbsra_pkg::ACT_GW_OFF: rd_mux = act_gw_ff;
         mbsra_pkg::ACT_CTRL_OFF: rd_mux = {31'h00000000, act_dhcp_ff};
         default: rd_hit = 1'b0;
      endcase
   end

   // Bus responses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= mbsra_pkg::RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= mbsra_pkg::RESP_OKAY;
         rdata_ff <= 32'h00000000;
      end else begin
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? mbsra_pkg::RESP_OKAY : mbsra_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_hit ? mbsra_pkg::RESP_OKAY : mbsra_pkg::RESP_SLVERR;
            rdata_ff <= rd_mux;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   bad_func_a: assert property (cmd_go && !drop_now && !fc_ok |=> exc_ff == mbsra_pkg::EXC_FUNC
      && done_ff && state_ff == ST_IDLE) else $error("unsupported function not refused");
   range_exc_a: assert property (cmd_go && !drop_now && fc_ok && range_bad
      |=> exc_ff == mbsra_pkg::EXC_ADDR) else $error("out of range not refused");
   drop_quiet_a: assert property (cmd_go && drop_now |=> drop_ff && state_ff == ST_IDLE
      && exc_ff == mbsra_pkg::EXC_NONE) else $error("foreign frame not dropped");
   no_write_a: assert property (state_ff == ST_RD |-> !wif.we)
      else $error("read wrote store");
   write_seq_a: assert property (state_ff == ST_WR |=> state_ff == ST_DONE ##1 done_ff)
      else $error("write not completed");
   space_sel_a: assert property (state_ff == ST_RD |-> wif.rd_ro ==
      (fc_ff == mbsra_pkg::FC_RD_RO)) else $error("wrong space");
   restart_a: assert property ($changed(act_ip_ff) |-> $past(wr_ok && sel_cctl))
      else $error("setting applied without restart");
   port_a: assert property (tcp_port == mbsra_pkg::TCP_PORT)
      else $error("tcp port wrong");
   bhold_a: assert property (bvalid_ff && !s_axi_bready |=> bvalid_ff)
      else $error("bvalid dropped");
   multi_step_a: assert property (state_ff == ST_DONE && fc_ff == mbsra_pkg::FC_WR_MULTI
      |=> cnt_ff == $past(cnt_ff) + 16'h0001) else $error("word step missed");
   read_c: cover property (state_ff == ST_RD ##2 done_ff);
   write_c: cover property (state_ff == ST_WR);
   exc_c: cover property (exc_ff == mbsra_pkg::EXC_ADDR);
   restart_c: cover property (wr_ok && sel_cctl && s_axi_wdata[mbsra_pkg::CTRL_RESTART]);
endmodule
`default_nettype wire

/* File: test/mbsra_bm.sv */
// Bus master model acting as the request-issuing master of the handler
`timescale 1ns/10ps
`default_nettype none
module mbsra_bm (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end
   // Handshakes are sampled half a cycle early, where they equal the edge value
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic aw;
      logic w;
      logic b;
      logic ta;
      logic tw;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         ta = s_axi_awready && !aw;
         tw = s_axi_wready && !w;
         b = s_axi_bvalid && aw && w;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) begin
            s_axi_awvalid <= 1'b0;
            aw = 1'b1;
         end
         if (tw) begin
            s_axi_wvalid <= 1'b0;
            w = 1'b1;
         end
         if (b) s_axi_bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      logic ta;
      logic t;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar = 1'b0;
      t = 1'b0;
      while (!t) begin
         @(negedge aclk);
         ta = s_axi_arready && !ar;
         t = s_axi_rvalid && ar;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) begin
            s_axi_arvalid <= 1'b0;
            ar = 1'b1;
         end
         if (t) s_axi_rready <= 1'b0;
      end
   endtask
   // Start address is given as listed, one-based
   task automatic at(input int listed, input logic [15:0] qty);
      logic [1:0] r;
      wr(mbsra_pkg::REQ_ADDR_OFF, {qty, 16'(listed - 1)}, 4'hF, r);
   endtask
   // One request; mode is {serial frame, check value good}
   task automatic rq(input logic [7:0] fc, input logic [7:0] id, input logic [1:0] mode,
                     input logic [15:0] wd, output logic [31:0] rsp);
      logic [1:0] r;
      int n;
      wr(mbsra_pkg::REQ_DATA_OFF, {16'h0000, wd}, 4'hF, r);
      wr(mbsra_pkg::REQ_CMD_OFF, {1'b1, mode, 13'h0000, id, fc}, 4'hF, r);
      n = 0;
      rsp = 32'h00000000;
      while (rsp[31] !== 1'b1 && n < 20) begin
         rd(mbsra_pkg::RSP_OFF, rsp, r);
         n++;
      end
   endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench of the register access handler
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] tcp_port;
   int fail_count;
   int n_tests;
   int seed;
   int cyc;
   logic [31:0] v;
   logic [1:0] r;
   logic [15:0] x;
   logic [15:0] y;
   int a;
   mbsra_top u_mbsra_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tcp_port);
   mbsra_bm u_mbsra_bm (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic [31:0] ok(input logic [15:0] w);
      return {2'b10, 14'h0000, w};
   endfunction
   function automatic logic [31:0] exc(input logic [7:0] e);
      return {2'b10, 6'h00, e, 16'h0000};
   endfunction
   function automatic logic [31:0] dflt(input int i);
      case (i)
         0: return {24'h000000, mbsra_pkg::ID_RST};
         1: return mbsra_pkg::IP_RST;
         2: return mbsra_pkg::MASK_RST;
         3: return mbsra_pkg::GW_RST;
         default: return 32'h00000000;
      endcase
   endfunction
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      seed = 49;
      cyc = 0;
      fail_count = 0;
      n_tests = 0;
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk(32'(tcp_port), 32'h000001F6);
      for (int i = 0; i < 5; i++) begin
         u_mbsra_bm.rd(8'(mbsra_pkg::ACT_ID_OFF + 8'(4 * i)), v, r);
         chk(v, dflt(i));
      end
      // New settings stay staged until restart
      v = $random(seed);
      u_mbsra_bm.wr(mbsra_pkg::CFG_ID_OFF, 32'h00000005, 4'hF, r);
      u_mbsra_bm.wr(mbsra_pkg::CFG_IP_OFF, v, 4'hF, r);
      u_mbsra_bm.rd(mbsra_pkg::CFG_ID_OFF, v, r);
      chk(v, 32'h00000005);
      u_mbsra_bm.rd(mbsra_pkg::ACT_IP_OFF, v, r);
      chk(v, mbsra_pkg::IP_RST);
      u_mbsra_bm.wr(mbsra_pkg::CFG_CTRL_OFF, 32'h00000002, 4'hF, r);
      u_mbsra_bm.rd(mbsra_pkg::ACT_ID_OFF, v, r);
      chk(v, 32'h00000005);
      // Separate read-only and read/write spaces at one address
      a = 1 + ($unsigned($random(seed)) % 1000);
      x = 16'($random(seed));
      y = ~x;
      u_mbsra_bm.wr(mbsra_pkg::RO_WR_OFF, {6'h00, 10'(a - 1), x}, 4'hF, r);
      u_mbsra_bm.at(a, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_WR_ONE, 8'h05, 2'b00, y, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      u_mbsra_bm.at(a, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RO, 8'h05, 2'b00, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(x));
      u_mbsra_bm.at(a, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      // Two-word write at the top of the space, then read back
      x = 16'h0154;
      y = 16'hFF38;
      u_mbsra_bm.at(999, 16'h0002);
      u_mbsra_bm.rq(mbsra_pkg::FC_WR_MULTI, 8'h05, 2'b00, x, v);
      u_mbsra_bm.rq(mbsra_pkg::FC_WR_MULTI, 8'h05, 2'b00, y, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      u_mbsra_bm.at(999, 16'h0002);
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(x));
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      // Range limit: span past the top, beyond the top, zero count
      for (int i = 0; i < 3; i++) begin
         u_mbsra_bm.at(i == 0 ? 1000 : (i == 1 ? 1001 : 1), 16'(2 - i));
         u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
         chk(v & 32'hC0FF0000, exc(mbsra_pkg::EXC_ADDR));
      end
      // Bit-object codes are refused and leave the words alone
      for (int i = 0; i < 4; i++) begin
         u_mbsra_bm.at(1000, 16'h0001);
         u_mbsra_bm.rq(i == 3 ? 8'h0F : (i == 2 ? 8'h05 : 8'(i + 1)), 8'h05, 2'b00, 16'h1234, v);
         chk(v & 32'hC0FF0000, exc(mbsra_pkg::EXC_FUNC));
      end
      u_mbsra_bm.at(1000, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      // Serial frames: bad check value, foreign identifier, then own identifier
      u_mbsra_bm.at(1000, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_WR_ONE, 8'h05, 2'b10, 16'h0BAD, v);
      chk({31'h0, v[30]}, 32'h00000001);
      u_mbsra_bm.at(1000, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_WR_ONE, 8'h06, 2'b11, 16'h0BAD, v);
      chk({31'h0, v[30]}, 32'h00000001);
      u_mbsra_bm.at(1000, 16'h0001);
      u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b11, 16'h0000, v);
      chk(v & 32'hC0FFFFFF, ok(y));
      // Random scaled setpoints written and read back
      for (int i = 0; i < 20; i++) begin
         a = 1 + ($unsigned($random(seed)) % 1000);
         x = 16'($unsigned($random(seed)) % 1000) * 16'h000A;
         u_mbsra_bm.at(a, 16'h0001);
         u_mbsra_bm.rq(mbsra_pkg::FC_WR_ONE, 8'h05, 2'b00, x, v);
         u_mbsra_bm.at(a, 16'h0001);
         u_mbsra_bm.rq(mbsra_pkg::FC_RD_RW, 8'h05, 2'b00, 16'h0000, v);
         chk(v & 32'hC0FFFFFF, ok(x));
      end
      // Bus errors: unmapped offset and partial strobe
      u_mbsra_bm.wr(8'h3C, 32'h00000000, 4'hF, r);
      chk(32'(r), 32'(mbsra_pkg::RESP_SLVERR));
      u_mbsra_bm.rd(8'h3C, v, r);
      chk(32'(r), 32'(mbsra_pkg::RESP_SLVERR));
      u_mbsra_bm.wr(mbsra_pkg::CFG_ID_OFF, 32'h00000009, 4'h3, r);
      chk(32'(r), 32'(mbsra_pkg::RESP_SLVERR));
      u_mbsra_bm.rd(mbsra_pkg::CFG_ID_OFF, v, r);
      chk(v, 32'h00000005);
      report_and_stop();
   end
endmodule
`default_nettype wire
